// >>> src/sawp_consts.svh
// offsets, field positions, reset values and timing figures of the strap and wake-up block
`ifndef SAWP_CONSTS_SVH
`define SAWP_CONSTS_SVH
`define SAWP_CLK_HZ         100000000
`define SAWP_DEBOUNCE_MS    16
`define SAWP_BLINK_TICK_MS  125
`define SAWP_RING_WINDOW_MS 100
`define SAWP_RING_PULSES    4'h3
`define SAWP_CFG_BASE_LO    16'h002e
`define SAWP_CFG_BASE_HI    16'h004e
`define SAWP_OFF_CTRL       8'h00
`define SAWP_OFF_LED        8'h04
`define SAWP_OFF_STATUS     8'h08
`define SAWP_OFF_EVT        8'h0c
`define SAWP_OFF_MASK       8'h10
`define SAWP_CTRL_BTN       0
`define SAWP_CTRL_SUPPLY    1
`define SAWP_CTRL_GPO0      2
`define SAWP_CTRL_GPO1      3
`define SAWP_CTRL_RING_EN   4
`define SAWP_CTRL_BTN_EN    5
`define SAWP_CTRL_W         6
`define SAWP_CTRL_RST       6'h00
`define SAWP_EVT_PRESS      0
`define SAWP_EVT_RING       1
`define SAWP_EVT_RELEASE    2
`define SAWP_EVT_W          3
`define SAWP_RESP_OKAY      2'h0
`define SAWP_RESP_SLVERR    2'h2
`endif

// >>> src/sawp_pkg.sv
// types shared by the strap and wake-up block
`include "sawp_consts.svh"
package sawp_pkg;
	typedef enum logic [2:0] {
		SAWP_LED_OFF, SAWP_LED_ON, SAWP_LED_Q25HZ, SAWP_LED_HALFHZ, SAWP_LED_1HZ, SAWP_LED_4HZ
	} sawp_led_mode_type;

	typedef struct packed {
		logic sys_rst_n;
		logic base;
		logic test;
		logic strap_a;
		logic strap_b;
		logic pol;
		logic btn_n;
		logic ring_n;
		logic s3;
		logic s5;
	} sawp_pins_type;

	typedef struct packed {
		sawp_pins_type s1;
		sawp_pins_type s2;
	} sawp_sync_state_type;

	typedef struct packed {
		logic led;
	} sawp_blink_state_type;

	typedef struct packed {
		logic                     aw_got;
		logic                     w_got;
		logic [7:0]               awaddr;
		logic [31:0]              wdata;
		logic [3:0]               wstrb;
		logic                     bvalid;
		logic [1:0]               bresp;
		logic                     rvalid;
		logic [31:0]              rdata;
		logic [1:0]               rresp;
		logic [`SAWP_CTRL_W-1:0]  ctrl;
		logic [2:0]               led1_mode;
		logic [2:0]               led2_mode;
		logic [`SAWP_EVT_W-1:0]   evt;
		logic [`SAWP_EVT_W-1:0]   mask;
		logic [1:0]               cap_cnt;
		logic                     cap_done;
		logic                     strap_a;
		logic                     strap_b;
		logic                     pol;
		logic                     rst_d;
		logic                     base_sel;
		logic                     test_mode;
		logic [23:0]              db_cnt;
		logic                     btn_pressed;
		logic                     ring_d;
		logic [3:0]               ring_cnt;
		logic [23:0]              ring_win;
		logic [23:0]              tick_cnt;
		logic [4:0]               phase;
	} sawp_state_type;
endpackage : sawp_pkg

// >>> src/sawp_led_if.sv
// link between the top and one led waveform generator
`timescale 1ns/10ps
`default_nettype none
interface sawp_led_if;
	sawp_pkg::sawp_led_mode_type mode;
	logic [4:0]                  phase;
	logic                        led;
	modport ctl (output mode, output phase, input led);
	modport gen (input mode, input phase, output led);
endinterface : sawp_led_if
`default_nettype wire

// >>> src/sawp_sync2.sv
// two-flop synchroniser for every pin that enters from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module sawp_sync2 (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire sawp_pkg::sawp_pins_type d,
	output var  sawp_pkg::sawp_pins_type q
);
	import sawp_pkg::*;
	sawp_sync_state_type st_r;
	sawp_sync_state_type st_nxt;

	// first stage feeds only the second stage
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.s2;
endmodule : sawp_sync2
`default_nettype wire

// >>> src/sawp_blink.sv
// one led output: steady level or blink picked from the shared phase counter
`timescale 1ns/10ps
`default_nettype none
module sawp_blink (
	input  wire logic aclk,
	input  wire logic aresetn,
	sawp_led_if.gen   led_io
);
	import sawp_pkg::*;
	sawp_blink_state_type st_r;
	sawp_blink_state_type st_nxt;

	// phase bit n has a period of 2^(n+1) ticks of 125 ms
	always_comb begin
		st_nxt = st_r;
		case (led_io.mode)
			SAWP_LED_ON:     st_nxt.led = 1'b1;
			SAWP_LED_Q25HZ:  st_nxt.led = led_io.phase[4];
			SAWP_LED_HALFHZ: st_nxt.led = led_io.phase[3];
			SAWP_LED_1HZ:    st_nxt.led = led_io.phase[2];
			SAWP_LED_4HZ:    st_nxt.led = led_io.phase[0];
			default:         st_nxt.led = 1'b0; // unused codes read as off
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign led_io.led = st_r.led;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_led_steady;
		(led_io.mode == SAWP_LED_ON) ##1 (led_io.mode == SAWP_LED_ON) |-> led_io.led;
	endproperty
	a_led_steady: assert property (p_led_steady) else $error("led not steady on");

	property p_led_1hz;
		(led_io.mode == SAWP_LED_1HZ) |=> (led_io.led == $past(led_io.phase[2]));
	endproperty
	a_led_1hz: assert property (p_led_1hz) else $error("1 Hz led off phase");
endmodule : sawp_blink
`default_nettype wire

// >>> src/sawp_top.sv
// strap capture, standby wake-up pins, led blinking and register slave of the block
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`include "sawp_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module sawp_top #(
	parameter logic [23:0] DEBOUNCE_CYCLES =
		24'(64'(`SAWP_DEBOUNCE_MS) * (`SAWP_CLK_HZ / 1000)),
	parameter logic [23:0] BLINK_TICK_CYCLES =
		24'(64'(`SAWP_BLINK_TICK_MS) * (`SAWP_CLK_HZ / 1000)),
	parameter logic [23:0] RING_WINDOW_CYCLES =
		24'(64'(`SAWP_RING_WINDOW_MS) * (`SAWP_CLK_HZ / 1000))
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq,
	input  wire logic        sys_reset_n,
	input  wire logic        cfg_base_sel_strap,
	input  wire logic        test_mode_strap,
	input  wire logic        pwr_led_cfg_strap_a,
	input  wire logic        pwr_led_cfg_strap_b,
	input  wire logic        supply_on_polarity_strap,
	input  wire logic        pwr_button_in_n,
	input  wire logic        ring_in_n,
	input  wire logic        sleep_s3_to_s5_in,
	input  wire logic        sleep_s4_s5_in,
	output logic             pwr_button_out_n_o,
	output logic             pwr_button_out_n_oe,
	output logic             supply_on_out_o,
	output logic             supply_on_out_oe,
	output logic             wake_request_n_o,
	output logic             wake_request_n_oe,
	output logic             led1_out,
	output logic             led2_out,
	output logic             test_mode,
	input  wire logic [15:0] io_addr,
	output logic [15:0]      cfg_index_addr,
	output logic             cfg_index_hit,
	output logic             cfg_data_hit
);
	import sawp_pkg::*;

	sawp_state_type         st_r;
	sawp_state_type         st_nxt;
	sawp_pins_type          pins_raw;
	sawp_pins_type          pins_s;
	logic                   func_mode;
	logic                   wake_pend;
	logic                   supply_act;
	logic                   raw_pressed;
	logic                   db_accept;
	logic                   ring_fall;
	logic                   rst_edge;
	logic [`SAWP_EVT_W-1:0] evt_set;
	logic [`SAWP_EVT_W-1:0] evt_clr;
	logic [31:0]            status_word;

	// gather the asynchronous pins and bring them onto aclk
	assign pins_raw.sys_rst_n = sys_reset_n;
	assign pins_raw.base      = cfg_base_sel_strap;
	assign pins_raw.test      = test_mode_strap;
	assign pins_raw.strap_a   = pwr_led_cfg_strap_a;
	assign pins_raw.strap_b   = pwr_led_cfg_strap_b;
	assign pins_raw.pol       = supply_on_polarity_strap;
	assign pins_raw.btn_n     = pwr_button_in_n;
	assign pins_raw.ring_n    = ring_in_n;
	assign pins_raw.s3        = sleep_s3_to_s5_in;
	assign pins_raw.s5        = sleep_s4_s5_in;

	sawp_sync2 u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (pins_raw),
		.q       (pins_s)
	);

	// shared pins take their power functions only with both straps low
	assign func_mode   = !st_r.strap_a && !st_r.strap_b;
	assign wake_pend   = (st_r.evt[`SAWP_EVT_PRESS] && st_r.ctrl[`SAWP_CTRL_BTN_EN]) ||
		(st_r.evt[`SAWP_EVT_RING] && st_r.ctrl[`SAWP_CTRL_RING_EN]);
	assign supply_act  = st_r.ctrl[`SAWP_CTRL_SUPPLY] || wake_pend;
	assign raw_pressed = !pins_s.btn_n;
	assign db_accept   = (raw_pressed != st_r.btn_pressed) &&
		(st_r.db_cnt == DEBOUNCE_CYCLES - 24'h000001);
	assign ring_fall   = st_r.ring_d && !pins_s.ring_n;
	assign rst_edge    = pins_s.sys_rst_n && !st_r.rst_d;

	// button events only count while the button pin carries its power function; ring events count in every mode
	assign evt_set[`SAWP_EVT_PRESS]   = func_mode && db_accept && raw_pressed;
	assign evt_set[`SAWP_EVT_RELEASE] = func_mode && db_accept && !raw_pressed;
	assign evt_set[`SAWP_EVT_RING]    = ring_fall &&
		(st_r.ring_cnt == `SAWP_RING_PULSES - 4'h1);
	assign evt_clr = (st_r.aw_got && st_r.w_got && !st_r.bvalid &&
		st_r.awaddr == `SAWP_OFF_EVT && st_r.wstrb[0]) ?
		st_r.wdata[`SAWP_EVT_W-1:0] : '0;

	// sleep inputs are only reported; the chipset owns their levels
	assign status_word = {22'h000000, wake_pend, pins_s.btn_n, pins_s.s5, pins_s.s3,
		st_r.btn_pressed, st_r.pol, st_r.strap_b, st_r.strap_a, st_r.test_mode, st_r.base_sel};

	// next-state logic for the whole block
	always_comb begin
		st_nxt = st_r;

		// standby straps: wait for the synchroniser to fill, then freeze
		if (!st_r.cap_done) begin
			if (st_r.cap_cnt == 2'h2) begin
				st_nxt.strap_a  = pins_s.strap_a;
				st_nxt.strap_b  = pins_s.strap_b;
				st_nxt.pol      = pins_s.pol;
				st_nxt.cap_done = 1'b1;
			end else begin
				st_nxt.cap_cnt = st_r.cap_cnt + 2'h1;
			end
		end

		// base and test straps follow the trailing edge of system reset
		st_nxt.rst_d = pins_s.sys_rst_n;
		if (rst_edge) begin
			st_nxt.base_sel  = pins_s.base;
			st_nxt.test_mode = pins_s.test;
		end

		// debounce: level must differ for the whole window before it is taken
		if (raw_pressed == st_r.btn_pressed) begin
			st_nxt.db_cnt = 24'h000000;
		end else if (db_accept) begin
			st_nxt.btn_pressed = raw_pressed;
			st_nxt.db_cnt      = 24'h000000;
		end else begin
			st_nxt.db_cnt = st_r.db_cnt + 24'h000001;
		end

		// ring: enough falling edges inside one window make a wake event
		st_nxt.ring_d = pins_s.ring_n;
		if (st_r.ring_cnt != 4'h0) begin
			st_nxt.ring_win = st_r.ring_win + 24'h000001;
			if (st_r.ring_win == RING_WINDOW_CYCLES - 24'h000001) begin
				st_nxt.ring_cnt = 4'h0; // window ran out, start over
			end
		end
		if (ring_fall) begin
			if (evt_set[`SAWP_EVT_RING]) begin
				st_nxt.ring_cnt = 4'h0;
			end else if (st_r.ring_cnt == 4'h0) begin
				st_nxt.ring_cnt = 4'h1;
				st_nxt.ring_win = 24'h000000;
			end else begin
				st_nxt.ring_cnt = st_r.ring_cnt + 4'h1;
			end
		end

		// 8 Hz tick drives the shared blink phase
		if (st_r.tick_cnt == BLINK_TICK_CYCLES - 24'h000001) begin
			st_nxt.tick_cnt = 24'h000000;
			st_nxt.phase    = st_r.phase + 5'h01;
		end else begin
			st_nxt.tick_cnt = st_r.tick_cnt + 24'h000001;
		end

		// bus write side: address and data are taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_nxt.w_got = 1'b1;
			st_nxt.wdata = s_axi_wdata;
			st_nxt.wstrb = s_axi_wstrb;
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got  = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp  = `SAWP_RESP_OKAY;
			if (st_r.awaddr == `SAWP_OFF_CTRL) begin
				if (st_r.wstrb[0]) begin
					st_nxt.ctrl = st_r.wdata[`SAWP_CTRL_W-1:0];
				end
			end else if (st_r.awaddr == `SAWP_OFF_LED) begin
				if (st_r.wstrb[0]) begin
					st_nxt.led1_mode = st_r.wdata[2:0];
					st_nxt.led2_mode = st_r.wdata[6:4];
				end
			end else if (st_r.awaddr == `SAWP_OFF_MASK) begin
				if (st_r.wstrb[0]) begin
					st_nxt.mask = st_r.wdata[`SAWP_EVT_W-1:0];
				end
			end else if (st_r.awaddr == `SAWP_OFF_STATUS || st_r.awaddr == `SAWP_OFF_EVT) begin
				st_nxt.bresp = `SAWP_RESP_OKAY; // status ignores writes, events clear below
			end else begin
				st_nxt.bresp = `SAWP_RESP_SLVERR;
			end
		end

		// set beats clear so an event landing on a clear is not lost
		st_nxt.evt = (st_r.evt & ~evt_clr) | evt_set;

		// bus read side: one read at a time, data captured on acceptance
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp  = `SAWP_RESP_OKAY;
			st_nxt.rdata  = 32'h00000000;
			if (s_axi_araddr == `SAWP_OFF_CTRL) begin
				st_nxt.rdata = {26'h0000000, st_r.ctrl};
			end else if (s_axi_araddr == `SAWP_OFF_LED) begin
				st_nxt.rdata = {25'h0000000, st_r.led2_mode, 1'b0, st_r.led1_mode};
			end else if (s_axi_araddr == `SAWP_OFF_STATUS) begin
				st_nxt.rdata = status_word;
			end else if (s_axi_araddr == `SAWP_OFF_EVT) begin
				st_nxt.rdata = {29'h00000000, st_r.evt};
			end else if (s_axi_araddr == `SAWP_OFF_MASK) begin
				st_nxt.rdata = {29'h00000000, st_r.mask};
			end else begin
				st_nxt.rresp = `SAWP_RESP_SLVERR;
			end
		end
	end

	// all state in one register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// handshake outputs
	assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
	assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
	assign s_axi_arready = !st_r.rvalid;
	assign s_axi_bvalid  = st_r.bvalid;
	assign s_axi_bresp   = st_r.bresp;
	assign s_axi_rvalid  = st_r.rvalid;
	assign s_axi_rdata   = st_r.rdata;
	assign s_axi_rresp   = st_r.rresp;
	assign irq           = |(st_r.evt & st_r.mask);

	// configuration pair decode; low strap keeps the common default pair
	assign cfg_index_addr = st_r.base_sel ? `SAWP_CFG_BASE_HI : `SAWP_CFG_BASE_LO;
	assign cfg_index_hit  = (io_addr == cfg_index_addr);
	assign cfg_data_hit   = (io_addr == cfg_index_addr + 16'h0001);
	assign test_mode      = st_r.test_mode;

	// button out: open-drain low while held, else standby out 0 push-pull
	assign pwr_button_out_n_o  = func_mode ? 1'b0 : st_r.ctrl[`SAWP_CTRL_GPO0];
	assign pwr_button_out_n_oe = func_mode ?
		(st_r.btn_pressed || st_r.ctrl[`SAWP_CTRL_BTN]) : 1'b1;

	// supply on: stage type follows the polarity strap; else standby out 1
	assign supply_on_out_o  = func_mode ?
		(st_r.pol ? supply_act : 1'b0) : st_r.ctrl[`SAWP_CTRL_GPO1];
	assign supply_on_out_oe = func_mode ? (st_r.pol ? 1'b1 : supply_act) : 1'b1;

	// wake request is open-drain so it works with only standby pull-up
	assign wake_request_n_o  = 1'b0;
	assign wake_request_n_oe = wake_pend;

	sawp_led_if led1_if ();
	sawp_led_if led2_if ();
	assign led1_if.mode  = sawp_led_mode_type'(st_r.led1_mode);
	assign led1_if.phase = st_r.phase;
	assign led2_if.mode  = sawp_led_mode_type'(st_r.led2_mode);
	assign led2_if.phase = st_r.phase;
	assign led1_out      = led1_if.led;
	assign led2_out      = led2_if.led;

	sawp_blink u_led1 (
		.aclk    (aclk),
		.aresetn (aresetn),
		.led_io  (led1_if.gen)
	);

	sawp_blink u_led2 (
		.aclk    (aclk),
		.aresetn (aresetn),
		.led_io  (led2_if.gen)
	);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_base_capture;
		rst_edge |=> (st_r.base_sel == $past(pins_s.base));
	endproperty
	a_base_capture: assert property (p_base_capture) else $error("base strap not caught");

	property p_base_hold;
		!rst_edge |=> $stable(st_r.base_sel);
	endproperty
	a_base_hold: assert property (p_base_hold) else $error("base strap moved");

	property p_base_low;
		!st_r.base_sel |-> cfg_index_addr == 16'h002e && (cfg_data_hit == (io_addr == 16'h002f));
	endproperty
	a_base_low: assert property (p_base_low) else $error("low pair decode wrong");

	property p_base_high;
		st_r.base_sel |-> cfg_index_addr == 16'h004e && (cfg_data_hit == (io_addr == 16'h004f));
	endproperty
	a_base_high: assert property (p_base_high) else $error("high pair decode wrong");

	property p_func_pins;
		func_mode |-> !pwr_button_out_n_o && (pwr_button_out_n_oe == (st_r.btn_pressed
			|| st_r.ctrl[`SAWP_CTRL_BTN]));
	endproperty
	a_func_pins: assert property (p_func_pins) else $error("button out not open-drain");

	property p_gpio_pins;
		(st_r.strap_a || st_r.strap_b) |-> pwr_button_out_n_oe && supply_on_out_oe;
	endproperty
	a_gpio_pins: assert property (p_gpio_pins) else $error("standby outputs not driven");

	property p_pol_low;
		(func_mode && !st_r.pol) |-> !supply_on_out_o && (supply_on_out_oe == supply_act);
	endproperty
	a_pol_low: assert property (p_pol_low) else $error("supply on not open-drain low");

	property p_pol_high;
		(func_mode && st_r.pol) |-> supply_on_out_oe && (supply_on_out_o == supply_act);
	endproperty
	a_pol_high: assert property (p_pol_high) else $error("supply on not push-pull high");

	property p_test_capture;
		rst_edge |=> (test_mode == $past(pins_s.test));
	endproperty
	a_test_capture: assert property (p_test_capture) else $error("test strap not caught");

	property p_debounce;
		$changed(st_r.btn_pressed) |-> $past(st_r.db_cnt) == DEBOUNCE_CYCLES - 24'h000001;
	endproperty
	a_debounce: assert property (p_debounce) else $error("button taken early");

	property p_wake;
		(evt_set[`SAWP_EVT_RING] && st_r.ctrl[`SAWP_CTRL_RING_EN] && !st_nxt.bvalid)
			|=> wake_request_n_oe && !wake_request_n_o;
	endproperty
	a_wake: assert property (p_wake) else $error("ring did not request wake");

	property p_ring;
		(ring_fall && st_r.ring_cnt == `SAWP_RING_PULSES - 4'h1) |=> st_r.evt[`SAWP_EVT_RING];
	endproperty
	a_ring: assert property (p_ring) else $error("ring train missed");

	property p_supply_wake;
		(func_mode && wake_pend) |-> (st_r.pol ? supply_on_out_o : supply_on_out_oe);
	endproperty
	a_supply_wake: assert property (p_supply_wake) else $error("supply not switched on");

	property p_strap_frozen;
		st_r.cap_done |=> $stable({st_r.strap_a, st_r.strap_b, st_r.pol});
	endproperty
	a_strap_frozen: assert property (p_strap_frozen) else $error("standby straps moved");
endmodule : sawp_top
`default_nettype wire

// >>> test/sawp_chipset_model.sv
// chipset power controller and main supply as seen from the standby pins
`timescale 1ns/10ps
`default_nettype none
module sawp_chipset_model (
	input  wire logic       pwr_button_out_n_o,
	input  wire logic       pwr_button_out_n_oe,
	input  wire logic       supply_on_out_o,
	input  wire logic       supply_on_out_oe,
	input  wire logic       wake_request_n_o,
	input  wire logic       wake_request_n_oe,
	input  wire logic [1:0] sleep_code,
	output logic            sleep_s3_to_s5_in,
	output logic            sleep_s4_s5_in,
	output logic            btn_line,
	output logic            supply_line,
	output logic            wake_line
);
	// released lines float to the board pull-ups, never hold a stale level
	assign btn_line    = pwr_button_out_n_oe ? pwr_button_out_n_o : 1'b1;
	assign supply_line = supply_on_out_oe ? supply_on_out_o : 1'b1;
	assign wake_line   = wake_request_n_oe ? wake_request_n_o : 1'b1;
	// sleep code: 0 working, 1 s3, 2 s4, 3 s5
	assign sleep_s3_to_s5_in = (sleep_code != 2'h0);
	assign sleep_s4_s5_in    = sleep_code[1];
endmodule : sawp_chipset_model
`default_nettype wire

// >>> test/strap_and_wakeup_pins_bench.sv
// self-checking bench of the strap and wake-up block
`timescale 1ns/10ps
`default_nettype none
module strap_and_wakeup_pins_bench;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, irq, sys_reset_n, cfg_base_sel_strap, test_mode_strap;
	logic        pwr_led_cfg_strap_a, pwr_led_cfg_strap_b, supply_on_polarity_strap;
	logic        pwr_button_in_n, ring_in_n, sleep_s3_to_s5_in, sleep_s4_s5_in;
	logic        pwr_button_out_n_o, pwr_button_out_n_oe, supply_on_out_o, supply_on_out_oe;
	logic        wake_request_n_o, wake_request_n_oe, led1_out, led2_out, test_mode;
	logic        cfg_index_hit, cfg_data_hit, btn_line, supply_line, wake_line, st;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs, sleep_code;
	logic [15:0] io_addr, cfg_index_addr;
	logic [5:0]  ctl;
	logic [4:0]  s;
	int          n_fail, cmp_count, i, k, n, e;

	// short counts keep debounce, blink and ring windows inside a brief run
	sawp_top #(.DEBOUNCE_CYCLES(24'h000014), .BLINK_TICK_CYCLES(24'h000004),
		.RING_WINDOW_CYCLES(24'h000032)) sawp_top_inst (.*);
	sawp_chipset_model sawp_chipset_model_inst (.*);

	// free-running clock, 10 ns
	always #5 aclk = ~aclk;

	task automatic final_report;
		$display("compares %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic hang;
		n_fail++;
		$display("mismatch at %0t: wait ran out", $time);
		final_report();
	endtask : hang

	task automatic cyc(input int c);
		repeat (c) @(posedge aclk);
	endtask : cyc

	// ready is combinational of registers, so the negedge value is what the edge sees
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int j = 0; j < 50; j++) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge aclk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			if (tb) begin
				s_axi_bready <= 1'b0;
				return;
			end
		end
		hang();
	endtask : wr

	task automatic rd(input logic [7:0] a);
		logic ta, tr;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int j = 0; j < 50; j++) begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			rdat = s_axi_rdata;
			rs = s_axi_rresp;
			tr = s_axi_rvalid;
			@(posedge aclk);
			if (ta)
				s_axi_arvalid <= 1'b0;
			if (tr) begin
				s_axi_rready <= 1'b0;
				return;
			end
		end
		hang();
	endtask : rd

	// straps packed {polarity, led b, led a, test, base}
	task automatic rst(input logic [4:0] v);
		@(posedge aclk);
		{supply_on_polarity_strap, pwr_led_cfg_strap_b, pwr_led_cfg_strap_a} <= v[4:2];
		{test_mode_strap, cfg_base_sel_strap} <= v[1:0];
		aresetn <= 1'b0;
		sys_reset_n <= 1'b0;
		cyc(16);
		aresetn <= 1'b1;
		cyc(3);
		sys_reset_n <= 1'b1;
		cyc(8);
	endtask : rst

	function automatic logic [9:0] status_exp(input logic [4:0] v, input logic [1:0] c);
		return {1'b0, 1'b1, c[1], c != 2'h0, 1'b0, v};
	endfunction : status_exp

	// expected {button line, supply line, supply enable}
	function automatic logic [2:0] pins_exp(input logic [4:0] v, input logic [5:0] c);
		if (v[3] || v[2])
			return {c[2], c[3], 1'b1};
		if (v[4])
			return {~c[0], c[1], 1'b1};
		return {~c[0], ~c[1], c[1]};
	endfunction : pins_exp

	// a hang anywhere ends the run through the same report
	initial begin
		cyc(100000);
		hang();
	end

	initial begin
		{aclk, aresetn, sys_reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h00;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h00000;
		{s_axi_wdata, io_addr, sleep_code} = 50'h0;
		s_axi_wstrb = 4'hf;
		{pwr_button_in_n, ring_in_n} = 2'h3;
		n_fail = 0;
		cmp_count = 0;
		void'($urandom(32'h2f661699));
		// four strap settings, function mode with both polarities in the last two
		for (k = 3; k >= 0; k--) begin
			// led strap a alone high once; strap b alone or both high at random
			st = 1'($urandom);
			s = {k[0], k[0] & k[1], k[1] & (~k[0] | st), 2'($urandom)};
			cyc(1);
			sleep_code <= 2'($urandom);
			rst(s);
			{supply_on_polarity_strap, pwr_led_cfg_strap_b, pwr_led_cfg_strap_a} <= ~s[4:2];
			io_addr <= s[0] ? 16'h004f : 16'h002f;
			rd(8'h08);
			chk(rdat[9:0], status_exp(s, sleep_code));
			chk(test_mode, s[1]);
			chk(cfg_index_addr, s[0] ? 16'h004e : 16'h002e);
			chk({cfg_index_hit, cfg_data_hit}, 2'b01);
			for (i = 0; i < 3; i++) begin
				ctl = {2'h0, 4'($urandom)};
				wr(8'h00, {26'h0, ctl});
				@(negedge aclk);
				chk({btn_line, supply_line, supply_on_out_oe}, pins_exp(s, ctl));
			end
		end
		// a lone system reset recaptures the base strap
		cyc(1);
		cfg_base_sel_strap <= ~s[0];
		sys_reset_n <= 1'b0;
		cyc(4);
		sys_reset_n <= 1'b1;
		cyc(6);
		chk(cfg_index_addr, s[0] ? 16'h002e : 16'h004e);
		// a bounce shorter than the debounce time is ignored
		wr(8'h10, 32'h7);
		wr(8'h00, 32'h20);
		pwr_button_in_n <= 1'b0;
		cyc(12);
		pwr_button_in_n <= 1'b1;
		cyc(30);
		pwr_button_in_n <= 1'b0;
		cyc(18);
		@(negedge aclk);
		chk({irq, btn_line}, 2'b01);
		cyc(12);
		@(negedge aclk);
		chk({irq, btn_line, wake_line, supply_line}, 4'h8);
		rd(8'h0c);
		chk(rdat[2:0], 3'h1);
		pwr_button_in_n <= 1'b1;
		cyc(30);
		wr(8'h0c, 32'h7);
		@(negedge aclk);
		chk({irq, wake_line}, 2'b01);
		// three ring pulses inside the window wake the system
		wr(8'h00, 32'h10);
		for (i = 0; i < 3; i++) begin
			ring_in_n <= 1'b0;
			cyc(3);
			ring_in_n <= 1'b1;
			cyc(4);
		end
		cyc(8);
		@(negedge aclk);
		chk({irq, wake_line}, 2'b10);
		wr(8'h0c, 32'h7);
		// pulses spread wider than the window never add up to a wake
		for (i = 0; i < 3; i++) begin
			ring_in_n <= 1'b0;
			cyc(3);
			ring_in_n <= 1'b1;
			cyc(30);
		end
		@(negedge aclk);
		chk({irq, wake_line}, 2'b01);
		// blink rates counted as toggles over 256 cycles, led2 held steady on
		for (k = 2; k < 6; k++) begin
			wr(8'h04, 32'h10 | 32'(k));
			e = (k == 5) ? 64 : 4 << (k - 2);
			n = 0;
			@(negedge aclk);
			st = led1_out;
			for (i = 0; i < 256; i++) begin
				@(negedge aclk);
				n += (led1_out !== st);
				st = led1_out;
			end
			chk({31'h0, n >= e - 1 && n <= e + 1}, 32'h1);
			chk(led2_out, 1'b1);
		end
		wr(8'h04, 32'h0);
		@(negedge aclk);
		chk({led1_out, led2_out}, 2'b00);
		// unmapped address is refused both ways
		wr(8'h20, 32'h1);
		chk(rs, 2'h2);
		rd(8'h20);
		chk(rs, 2'h2);
		final_report();
	end
endmodule : strap_and_wakeup_pins_bench
`default_nettype wire
